//--- dsl_host_model.sv
// serial master model that shifts words into the latch block
`timescale 1ns/1ps
`default_nettype none
module dsl_host_model (
    input wire logic i_clk,
    output logic o_sclk,
    output logic o_serial_data_in,
    output logic o_strobe
);
    initial begin
        o_sclk = 1'b0;
        o_serial_data_in = 1'b0;
        o_strobe = 1'b0;
    end
    // 400 ns link period, well under the 20 MHz ceiling
    task automatic send(input logic [31:0] w, input int n);
        @(posedge i_clk);
        for (int i = n - 1; i >= 0; i--) begin
            o_serial_data_in <= w[i];
            repeat (4) @(posedge i_clk);
            o_sclk <= 1'b1;
            repeat (4) @(posedge i_clk);
            o_sclk <= 1'b0;
        end
        o_serial_data_in <= ~w[0]; // no stale bit left on a released line
        repeat (4) @(posedge i_clk);
        o_strobe <= 1'b1;
        repeat (8) @(posedge i_clk);
        o_strobe <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask
endmodule
`default_nettype wire

//--- dsl_latch_props.sv
// port-level assertions for the serial divider latch block
`timescale 1ns/1ps
`default_nettype none
module dsl_latch_props (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_latch_load_strobe,
    input wire logic [1:0] o_if_prescaler_sel,
    input wire logic [6:0] o_if_prescaler_modulus,
    input wire logic [1:0] o_rf_prescaler_sel,
    input wire logic [6:0] o_rf_prescaler_modulus,
    input wire logic [2:0] o_if_pump_current,
    input wire logic [2:0] o_rf_pump_current,
    input wire logic o_if_pump_hiz,
    input wire logic o_rf_pump_hiz,
    input wire logic o_if_powered_down,
    input wire logic o_if_dividers_load,
    input wire logic o_if_input_hiz,
    input wire logic o_rf_powered_down,
    input wire logic o_rf_dividers_load,
    input wire logic o_rf_input_hiz,
    input wire logic o_ref_osc_disable,
    input wire logic o_fast_acquire_switch_pin,
    input wire logic o_outputs_active
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_b);
    a_if_pd_flags: assert property (
        o_if_powered_down == o_if_dividers_load &&
        o_if_powered_down == o_if_input_hiz)
        else $error("if down flags disagree");
    a_rf_pd_flags: assert property (
        o_rf_powered_down == o_rf_dividers_load &&
        o_rf_powered_down == o_rf_input_hiz)
        else $error("rf down flags disagree");
    a_osc_both_down: assert property (
        o_ref_osc_disable == (o_if_powered_down && o_rf_powered_down))
        else $error("osc disable not both sections down");
    // pump must already float the cycle before the section goes down
    a_if_hiz_first: assert property (
        $rose(o_if_powered_down) |->
        $past(o_if_pump_hiz) && $past(i_latch_load_strobe, 2))
        else $error("if down without floating pump or strobe");
    a_rf_hiz_first: assert property (
        $rose(o_rf_powered_down) |->
        $past(o_rf_pump_hiz) && $past(i_latch_load_strobe, 2))
        else $error("rf down without floating pump or strobe");
    a_if_wake_strobe: assert property (
        $fell(o_if_powered_down) |-> $past(i_latch_load_strobe, 2))
        else $error("if woke without strobe");
    a_rf_wake_strobe: assert property (
        $fell(o_rf_powered_down) |-> $past(i_latch_load_strobe, 2))
        else $error("rf woke without strobe");
    a_if_prescale_map: assert property (
        o_if_prescaler_modulus == (7'h08 << o_if_prescaler_sel))
        else $error("if modulus mismatch");
    a_rf_prescale_map: assert property (
        o_rf_prescaler_modulus == (7'h08 << o_rf_prescaler_sel))
        else $error("rf modulus mismatch");
    a_idle_inactive: assert property (
        !o_outputs_active |-> o_if_pump_hiz && o_rf_pump_hiz &&
        !o_fast_acquire_switch_pin)
        else $error("output active before four writes");
    a_fast_max_pump: assert property (
        o_fast_acquire_switch_pin |->
        (o_if_pump_current == 3'h7 || o_rf_pump_current == 3'h7))
        else $error("fast switch without max current");
    c_if_down: cover property ($rose(o_if_powered_down));
    c_osc_off: cover property ($rose(o_ref_osc_disable));
    c_active: cover property ($rose(o_outputs_active));
    c_fast: cover property ($rose(o_fast_acquire_switch_pin));
endmodule
bind dsl_serial_latches dsl_latch_props chk (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_latch_load_strobe(i_latch_load_strobe),
    .o_if_prescaler_sel(o_if_prescaler_sel),
    .o_if_prescaler_modulus(o_if_prescaler_modulus),
    .o_rf_prescaler_sel(o_rf_prescaler_sel),
    .o_rf_prescaler_modulus(o_rf_prescaler_modulus),
    .o_if_pump_current(o_if_pump_current),
    .o_rf_pump_current(o_rf_pump_current),
    .o_if_pump_hiz(o_if_pump_hiz),
    .o_rf_pump_hiz(o_rf_pump_hiz),
    .o_if_powered_down(o_if_powered_down),
    .o_if_dividers_load(o_if_dividers_load),
    .o_if_input_hiz(o_if_input_hiz),
    .o_rf_powered_down(o_rf_powered_down),
    .o_rf_dividers_load(o_rf_dividers_load),
    .o_rf_input_hiz(o_rf_input_hiz),
    .o_ref_osc_disable(o_ref_osc_disable),
    .o_fast_acquire_switch_pin(o_fast_acquire_switch_pin),
    .o_outputs_active(o_outputs_active)
);
`default_nettype wire

//--- dsl_map.svh
// bit positions, reset values and timing counts of the serial latches
`ifndef DSL_MAP_SVH
`define DSL_MAP_SVH

`define DSL_WORD_W 24
`define DSL_WORD_RST 24'h000000
`define DSL_SEL_MSB 1
`define DSL_SEL_LSB 0

// reference latch fields
`define DSL_REF_DIV_MSB 15
`define DSL_REF_DIV_LSB 2
`define DSL_POL_BIT 17
`define DSL_TRI_BIT 18
`define DSL_MODE_MSB 20
`define DSL_MODE_LSB 19
`define DSL_CP_MSB 23
`define DSL_CP_LSB 21
`define DSL_CP_MAX 3'h7

// feedback divider latch fields
`define DSL_A_MSB 7
`define DSL_A_LSB 2
`define DSL_B_MSB 19
`define DSL_B_LSB 8
`define DSL_PRE_MSB 21
`define DSL_PRE_LSB 20
`define DSL_PD_BIT 22
`define DSL_FAST_BIT 23

// prescaler modulus values
`define DSL_PRE_P0 7'h08
`define DSL_PRE_P1 7'h10
`define DSL_PRE_P2 7'h20
`define DSL_PRE_P3 7'h40

// timing
`define DSL_CLK_PERIOD_NS 50
`define DSL_PD_SETTLE_NS 100
`define DSL_PD_SETTLE_CYC \
    ((`DSL_PD_SETTLE_NS + `DSL_CLK_PERIOD_NS - 1) / `DSL_CLK_PERIOD_NS)
`define DSL_PD_CNT_W 4
`define DSL_BITCNT_W 5

`endif

//--- dsl_pd_if.sv
// power-down request and status between latch logic and sequencer
`timescale 1ns/1ps
`default_nettype none
interface dsl_pd_if;
    logic load;
    logic pd_bit;
    logic tri_bit;
    logic pump_hiz;
    logic down;

    modport ctrl (output load, output pd_bit, output tri_bit,
                  input pump_hiz, input down);
    modport seq (input load, input pd_bit, input tri_bit,
                 output pump_hiz, output down);
endinterface
`default_nettype wire

//--- dsl_pd_seq.sv
// power-down sequencer for one synthesizer section
`timescale 1ns/1ps
`default_nettype none
`include "dsl_map.svh"
module dsl_pd_seq (
    input wire logic i_clk,
    input wire logic i_rst_b,
    dsl_pd_if.seq pd
);
    import dsl_pkg::*;

    dsl_pd_state_t state_reg;
    logic [`DSL_PD_CNT_W-1:0] cnt_reg;
    logic settled;

    assign settled = cnt_reg ==
        `DSL_PD_CNT_W'(`DSL_PD_SETTLE_CYC - 1);

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= DSL_PD_RUN;
        end else if (pd.load) begin
            if (!pd.pd_bit) begin
                state_reg <= DSL_PD_RUN; // [R16]
            end else if (pd.tri_bit || state_reg == DSL_PD_DOWN) begin
                state_reg <= DSL_PD_DOWN; // [R10] [R12]
            end else begin
                state_reg <= DSL_PD_TRISTATE; // [R9] [R11]
            end
        end else begin
            case (state_reg)
                DSL_PD_TRISTATE: begin
                    if (settled) begin
                        state_reg <= DSL_PD_DOWN; // [R9] [R11]
                    end
                end
                default: begin
                    state_reg <= state_reg;
                end
            endcase
        end
    end

    // pump settles three-stated before the section goes down
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt_reg <= '0;
        end else if (state_reg == DSL_PD_TRISTATE && !pd.load) begin
            cnt_reg <= cnt_reg + `DSL_PD_CNT_W'(1);
        end else begin
            cnt_reg <= '0;
        end
    end

    assign pd.pump_hiz = state_reg != DSL_PD_RUN; // [R9] [R11]
    assign pd.down = state_reg == DSL_PD_DOWN;
endmodule
`default_nettype wire

//--- dsl_pkg.sv
// types shared by the serial latch block
package dsl_pkg;

    typedef enum logic [1:0] {
        DSL_SEL_IF_REF = 2'b00,
        DSL_SEL_IF_FB = 2'b01,
        DSL_SEL_RF_REF = 2'b10,
        DSL_SEL_RF_FB = 2'b11
    } dsl_sel_t;

    typedef enum logic [1:0] {
        DSL_PD_RUN = 2'b00,
        DSL_PD_TRISTATE = 2'b01,
        DSL_PD_DOWN = 2'b10
    } dsl_pd_state_t;

endpackage

//--- dsl_serial_latches.sv
// serial input register and the four divider latches of a dual synthesizer
`timescale 1ns/1ps
`default_nettype none
`include "dsl_map.svh"

// Operation
// R1 - select 00 loads IF reference latch, 01 loads IF feedback latch
// R2 - select 10 loads RF reference latch, 11 loads RF feedback latch
// R3 - each feedback latch holds 6-bit A and 12-bit B counts
// R4 - data shifts on serial clock rise; strobe rise moves word to latch
// R5 - host sends full 24-bit words, possibly as three bytes
// R6 - host keeps strobe low while shifting, raises it after last bit
// R7 - host serial clock never exceeds 20 MHz
// R8 - outputs stay inactive until all four latches written once
// R9 - IF power-down with pump active: three-state pump, then power down
// R10 - IF power-down with pump already three-state: down at strobe
// R11 - RF power-down with pump active: three-state pump, then power down
// R12 - RF power-down with pump already three-state: down at strobe
// R13 - power-down holds dividers in load state, input high impedance
// R14 - reference oscillator disabled only when both sections powered down
// R15 - shift register and latches keep working during power-down
// R16 - writing power-down bit 0 restores section immediately
// R17 - polarity bit 1 for positive VCO slope, 0 for negative
// R18 - three-state bit 1 floats the pump, 0 normal
// R19 - three-bit code in reference latch sets pump current
// R20 - two feedback latch bits choose prescaler ratio
// R21 - prescaler code 00 8/9, 01 16/17, 10 32/33, 11 64/65
// R22 - IF gain bit forces max IF current and drives fastlock switch
// R23 - RF gain bit forces max RF current and drives fastlock switch
// R24 - words arrive MSB first; select bits are last two received
module dsl_serial_latches (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_serial_clk,
    input wire logic i_serial_data_in,
    input wire logic i_latch_load_strobe,
    output logic [13:0] o_if_reference_divider,
    output logic [5:0] o_if_a_count,
    output logic [11:0] o_if_b_count,
    output logic [1:0] o_if_prescaler_sel,
    output logic [6:0] o_if_prescaler_modulus,
    output logic [2:0] o_if_pump_current,
    output logic o_if_pump_hiz,
    output logic o_if_detector_polarity,
    output logic [1:0] o_if_mode,
    output logic o_if_powered_down,
    output logic o_if_dividers_load,
    output logic o_if_input_hiz,
    output logic [13:0] o_rf_reference_divider,
    output logic [5:0] o_rf_a_count,
    output logic [11:0] o_rf_b_count,
    output logic [1:0] o_rf_prescaler_sel,
    output logic [6:0] o_rf_prescaler_modulus,
    output logic [2:0] o_rf_pump_current,
    output logic o_rf_pump_hiz,
    output logic o_rf_detector_polarity,
    output logic [1:0] o_rf_mode,
    output logic o_rf_powered_down,
    output logic o_rf_dividers_load,
    output logic o_rf_input_hiz,
    output logic o_ref_osc_disable,
    output logic o_fast_acquire_switch_pin,
    output logic o_outputs_active,
    output logic o_short_word
);
    import dsl_pkg::*;

    logic [2:0] pin_sync;
    logic sclk_s;
    logic data_s;
    logic strobe_s;
    logic sclk_d_reg;
    logic strobe_d_reg;
    logic sclk_rise;
    logic strobe_rise;
    logic [`DSL_WORD_W-1:0] shift_reg;
    logic [`DSL_BITCNT_W-1:0] bitcnt_reg;
    logic [`DSL_WORD_W-1:0] if_ref_reg;
    logic [`DSL_WORD_W-1:0] if_fb_reg;
    logic [`DSL_WORD_W-1:0] rf_ref_reg;
    logic [`DSL_WORD_W-1:0] rf_fb_reg;
    logic [3:0] written_reg;
    logic short_reg;
    dsl_sel_t sel;
    logic active;
    logic if_fast;
    logic rf_fast;

    dsl_pd_if if_pd ();
    dsl_pd_if rf_pd ();

    // all three pins come from the host's domain
    dsl_sync #(
        .W(3)
    ) u_sync (
        .i_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_d({i_serial_clk, i_serial_data_in, i_latch_load_strobe}),
        .o_q(pin_sync)
    );

    assign sclk_s = pin_sync[2];
    assign data_s = pin_sync[1];
    assign strobe_s = pin_sync[0];

    // edge finding on the synchronised copies only
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sclk_d_reg <= 1'b0;
            strobe_d_reg <= 1'b0;
        end else begin
            sclk_d_reg <= sclk_s;
            strobe_d_reg <= strobe_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_d_reg;
    assign strobe_rise = strobe_s & ~strobe_d_reg;

    // data and clock pass equal sync depth, so they stay aligned
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            shift_reg <= `DSL_WORD_RST;
        end else if (sclk_rise) begin
            shift_reg <= {shift_reg[`DSL_WORD_W-2:0], data_s}; // [R4] [R24]
        end
    end

    // bits since the last strobe; saturates so long words stay legal
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            bitcnt_reg <= '0;
        end else if (strobe_rise) begin
            bitcnt_reg <= '0;
        end else if (sclk_rise &&
                bitcnt_reg != `DSL_BITCNT_W'(`DSL_WORD_W)) begin
            bitcnt_reg <= bitcnt_reg + `DSL_BITCNT_W'(1);
        end
    end

    // a short word is still latched; the flag only reports it
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            short_reg <= 1'b0;
        end else if (strobe_rise) begin
            short_reg <= bitcnt_reg != `DSL_BITCNT_W'(`DSL_WORD_W); // [R5]
        end
    end

    assign sel = dsl_sel_t'(shift_reg[`DSL_SEL_MSB:`DSL_SEL_LSB]);

    // latches load in every power state
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            if_ref_reg <= `DSL_WORD_RST;
            if_fb_reg <= `DSL_WORD_RST;
            rf_ref_reg <= `DSL_WORD_RST;
            rf_fb_reg <= `DSL_WORD_RST;
        end else if (strobe_rise) begin // [R4] [R15]
            if (sel == DSL_SEL_IF_REF) begin
                if_ref_reg <= shift_reg; // [R1]
            end else if (sel == DSL_SEL_IF_FB) begin
                if_fb_reg <= shift_reg; // [R1]
            end else if (sel == DSL_SEL_RF_REF) begin
                rf_ref_reg <= shift_reg; // [R2]
            end else begin
                rf_fb_reg <= shift_reg; // [R2]
            end
        end
    end

    // one bit per latch, set by its first write after reset
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            written_reg <= 4'h0;
        end else if (strobe_rise) begin
            written_reg[sel] <= 1'b1; // [R8]
        end
    end

    assign active = &written_reg; // [R8]

    // the sequencer sees the new power-down bit with the strobe edge;
    // the three-state bit is the one already held in the reference latch
    assign if_pd.load = strobe_rise && sel == DSL_SEL_IF_FB;
    assign if_pd.pd_bit = shift_reg[`DSL_PD_BIT];
    assign if_pd.tri_bit = if_ref_reg[`DSL_TRI_BIT]; // [R10]
    assign rf_pd.load = strobe_rise && sel == DSL_SEL_RF_FB;
    assign rf_pd.pd_bit = shift_reg[`DSL_PD_BIT];
    assign rf_pd.tri_bit = rf_ref_reg[`DSL_TRI_BIT]; // [R12]

    dsl_pd_seq u_if_seq (
        .i_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .pd(if_pd.seq)
    );

    dsl_pd_seq u_rf_seq (
        .i_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .pd(rf_pd.seq)
    );

    function automatic logic [6:0] modulus(input logic [1:0] code);
        logic [6:0] p;
        p = `DSL_PRE_P0;
        case (code)
            2'h0: p = `DSL_PRE_P0;
            2'h1: p = `DSL_PRE_P1;
            2'h2: p = `DSL_PRE_P2;
            default: p = `DSL_PRE_P3;
        endcase
        return p;
    endfunction

    // IF section
    assign if_fast = if_fb_reg[`DSL_FAST_BIT];
    assign o_if_reference_divider =
        if_ref_reg[`DSL_REF_DIV_MSB:`DSL_REF_DIV_LSB];
    assign o_if_a_count = if_fb_reg[`DSL_A_MSB:`DSL_A_LSB]; // [R3]
    assign o_if_b_count = if_fb_reg[`DSL_B_MSB:`DSL_B_LSB]; // [R3]
    assign o_if_prescaler_sel =
        if_fb_reg[`DSL_PRE_MSB:`DSL_PRE_LSB]; // [R20]
    assign o_if_prescaler_modulus =
        modulus(o_if_prescaler_sel); // [R21]
    assign o_if_pump_current = if_fast ? `DSL_CP_MAX
        : if_ref_reg[`DSL_CP_MSB:`DSL_CP_LSB]; // [R19] [R22]
    assign o_if_pump_hiz = ~active
        | if_ref_reg[`DSL_TRI_BIT] // [R18]
        | if_pd.pump_hiz; // [R9]
    assign o_if_detector_polarity = if_ref_reg[`DSL_POL_BIT]; // [R17]
    assign o_if_mode = if_ref_reg[`DSL_MODE_MSB:`DSL_MODE_LSB];
    assign o_if_powered_down = if_pd.down;
    assign o_if_dividers_load = if_pd.down; // [R13]
    assign o_if_input_hiz = if_pd.down; // [R13]

    // RF section
    assign rf_fast = rf_fb_reg[`DSL_FAST_BIT];
    assign o_rf_reference_divider =
        rf_ref_reg[`DSL_REF_DIV_MSB:`DSL_REF_DIV_LSB];
    assign o_rf_a_count = rf_fb_reg[`DSL_A_MSB:`DSL_A_LSB]; // [R3]
    assign o_rf_b_count = rf_fb_reg[`DSL_B_MSB:`DSL_B_LSB]; // [R3]
    assign o_rf_prescaler_sel =
        rf_fb_reg[`DSL_PRE_MSB:`DSL_PRE_LSB]; // [R20]
    assign o_rf_prescaler_modulus =
        modulus(o_rf_prescaler_sel); // [R21]
    assign o_rf_pump_current = rf_fast ? `DSL_CP_MAX
        : rf_ref_reg[`DSL_CP_MSB:`DSL_CP_LSB]; // [R19] [R23]
    assign o_rf_pump_hiz = ~active
        | rf_ref_reg[`DSL_TRI_BIT] // [R18]
        | rf_pd.pump_hiz; // [R11]
    assign o_rf_detector_polarity = rf_ref_reg[`DSL_POL_BIT]; // [R17]
    assign o_rf_mode = rf_ref_reg[`DSL_MODE_MSB:`DSL_MODE_LSB];
    assign o_rf_powered_down = rf_pd.down;
    assign o_rf_dividers_load = rf_pd.down; // [R13]
    assign o_rf_input_hiz = rf_pd.down; // [R13]

    // shared outputs
    assign o_ref_osc_disable = if_pd.down & rf_pd.down; // [R14]
    assign o_fast_acquire_switch_pin =
        active & (if_fast | rf_fast); // [R22] [R23]
    assign o_outputs_active = active; // [R8]
    assign o_short_word = short_reg;
endmodule
`default_nettype wire

//--- dsl_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module dsl_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            meta_reg <= '0;
            o_q <= '0;
        end else begin
            meta_reg <= i_d;
            o_q <= meta_reg;
        end
    end
endmodule
`default_nettype wire

//--- tb_dual_synth_serial_control_latches.sv
// self-checking bench for the serial divider latch block
`timescale 1ns/1ps
`default_nettype none
module tb_dual_synth_serial_control_latches;
    logic i_sys_clk = 1'b0;
    logic i_rst_b = 1'b0;
    wire i_serial_clk, i_serial_data_in, i_latch_load_strobe;
    wire [13:0] o_if_reference_divider, o_rf_reference_divider;
    wire [11:0] o_if_b_count, o_rf_b_count;
    wire [6:0] o_if_prescaler_modulus, o_rf_prescaler_modulus;
    wire [5:0] o_if_a_count, o_rf_a_count;
    wire [2:0] o_if_pump_current, o_rf_pump_current;
    wire [1:0] o_if_prescaler_sel, o_rf_prescaler_sel, o_if_mode, o_rf_mode;
    wire o_if_pump_hiz, o_rf_pump_hiz, o_if_detector_polarity;
    wire o_rf_detector_polarity, o_if_powered_down, o_rf_powered_down;
    wire o_if_dividers_load, o_rf_dividers_load, o_if_input_hiz;
    wire o_rf_input_hiz, o_ref_osc_disable, o_fast_acquire_switch_pin;
    wire o_outputs_active, o_short_word;
    logic [23:0] lat_m [4] = '{default: 24'h000000};
    logic [23:0] sr_m = 24'h000000;
    logic [3:0] wr_m = 4'h0;
    logic [1:0] pd_m = 2'h0;
    logic short_m = 1'b0;
    logic [31:0] seed = 32'h6b83c319;
    int fail_count = 0;
    int n_tests = 0;

    dsl_serial_latches dut (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_serial_clk(i_serial_clk),
        .i_serial_data_in(i_serial_data_in),
        .i_latch_load_strobe(i_latch_load_strobe),
        .o_if_reference_divider(o_if_reference_divider),
        .o_if_a_count(o_if_a_count),
        .o_if_b_count(o_if_b_count),
        .o_if_prescaler_sel(o_if_prescaler_sel),
        .o_if_prescaler_modulus(o_if_prescaler_modulus),
        .o_if_pump_current(o_if_pump_current),
        .o_if_pump_hiz(o_if_pump_hiz),
        .o_if_detector_polarity(o_if_detector_polarity),
        .o_if_mode(o_if_mode),
        .o_if_powered_down(o_if_powered_down),
        .o_if_dividers_load(o_if_dividers_load),
        .o_if_input_hiz(o_if_input_hiz),
        .o_rf_reference_divider(o_rf_reference_divider),
        .o_rf_a_count(o_rf_a_count),
        .o_rf_b_count(o_rf_b_count),
        .o_rf_prescaler_sel(o_rf_prescaler_sel),
        .o_rf_prescaler_modulus(o_rf_prescaler_modulus),
        .o_rf_pump_current(o_rf_pump_current),
        .o_rf_pump_hiz(o_rf_pump_hiz),
        .o_rf_detector_polarity(o_rf_detector_polarity),
        .o_rf_mode(o_rf_mode),
        .o_rf_powered_down(o_rf_powered_down),
        .o_rf_dividers_load(o_rf_dividers_load),
        .o_rf_input_hiz(o_rf_input_hiz),
        .o_ref_osc_disable(o_ref_osc_disable),
        .o_fast_acquire_switch_pin(o_fast_acquire_switch_pin),
        .o_outputs_active(o_outputs_active),
        .o_short_word(o_short_word)
    );
    dsl_host_model host (
        .i_clk(i_sys_clk),
        .o_sclk(i_serial_clk),
        .o_serial_data_in(i_serial_data_in),
        .o_strobe(i_latch_load_strobe)
    );

    initial forever #25 i_sys_clk = ~i_sys_clk;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [31:0] wd(logic [1:0] sel, logic [23:0] set,
                                       logic [23:0] clr);
        logic [31:0] r;
        r = rnd();
        return {8'h00, (((r[23:0] & ~clr) | set) & 24'hfffffc) | sel};
    endfunction

    // expected section outputs in port order
    function automatic logic [50:0] fsec(int s);
        logic [23:0] r;
        logic [23:0] f;
        r = lat_m[2*s];
        f = lat_m[2*s+1];
        return {r[15:2], f[7:2], f[19:8], f[21:20], 7'h08 << f[21:20],
            f[23] ? 3'h7 : r[23:21], ~&wr_m | r[18] | pd_m[s], r[17],
            r[20:19], {3{pd_m[s]}}};
    endfunction

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic check_all();
        chk("if", {o_if_reference_divider, o_if_a_count, o_if_b_count,
            o_if_prescaler_sel, o_if_prescaler_modulus, o_if_pump_current,
            o_if_pump_hiz, o_if_detector_polarity, o_if_mode,
            o_if_powered_down, o_if_dividers_load, o_if_input_hiz},
            fsec(0));
        chk("rf", {o_rf_reference_divider, o_rf_a_count, o_rf_b_count,
            o_rf_prescaler_sel, o_rf_prescaler_modulus, o_rf_pump_current,
            o_rf_pump_hiz, o_rf_detector_polarity, o_rf_mode,
            o_rf_powered_down, o_rf_dividers_load, o_rf_input_hiz},
            fsec(1));
        chk("misc", {o_ref_osc_disable, o_fast_acquire_switch_pin,
            o_outputs_active, o_short_word}, {&pd_m, &wr_m &
            (lat_m[1][23] | lat_m[3][23]), &wr_m, short_m});
    endtask

    // one word through the host; lat counts cycles to a power change
    task automatic wr(input logic [31:0] w, input int n, output int lat);
        logic [1:0] pd0;
        int k;
        pd0 = {o_if_powered_down, o_rf_powered_down};
        lat = 99;
        k = 0;
        fork
            host.send(w, n);
            begin
                while (!i_latch_load_strobe && k < 4000) begin
                    @(negedge i_sys_clk);
                    k++;
                end
                for (int c = 1; c <= 12 && lat == 99; c++) begin
                    @(negedge i_sys_clk);
                    if ({o_if_powered_down, o_rf_powered_down} != pd0)
                        lat = c;
                end
            end
        join
        if (k >= 4000) begin
            fail_count++;
            finish_test();
        end
        for (int i = n - 1; i >= 0; i--)
            sr_m = {sr_m[22:0], w[i]};
        lat_m[sr_m[1:0]] = sr_m;
        wr_m[sr_m[1:0]] = 1'b1;
        if (sr_m[0])
            pd_m[sr_m[1]] = sr_m[22];
        short_m = n < 24;
        repeat (6) @(negedge i_sys_clk);
        check_all();
    endtask

    initial begin
        int la, ls, lu, lx;
        repeat (8) @(posedge i_sys_clk);
        i_rst_b <= 1'b1;
        @(negedge i_sys_clk);
        check_all();
        for (int s = 0; s < 4; s++)
            wr(wd(s[1:0], 0, s[0] ? 24'hc00000 : 0), 24, lx);
        for (int p = 0; p < 8; p++)
            wr(wd({p[0], 1'b1}, 24'(p[2:1]) << 20, 24'hf00000),
                24, lx);
        for (int s = 0; s < 4; s++)
            wr(wd({s[0], 1'b1}, (s < 2) ? 24'h800000 : 0, 24'hc00000),
                24, lx);
        for (int s = 0; s < 2; s++) begin
            wr(wd({s[0], 1'b0}, 0, 24'h040000), 24, lx);
            wr(wd({s[0], 1'b1}, 24'h400000, 24'h800000), 24, ls);
            wr(wd({s[0], 1'b1}, 0, 24'hc00000), 24, lu);
            wr(wd({s[0], 1'b0}, 24'h040000, 0), 24, lx);
            wr(wd({s[0], 1'b1}, 24'h400000, 24'h800000), 24, la);
            chk("sync lat", ls, la + 2);
            chk("wake lat", lu, la);
        end
        wr(wd(2'b00, 0, 0), 20, lx);
        wr(wd(2'b10, 0, 0) | 32'h0a000000, 28, lx);
        finish_test();
    end
endmodule
`default_nettype wire
